// ### common/ncsr_pkg.sv
/*
 * Constants and types of the host register bank and system control block:
 * offsets, reset values, field positions, command codes and timing.
 * Assumes a 10 MHz clock and a 7-bit byte offset from the I/O or memory base.
 */
package ncsr_pkg;

    localparam int NCSR_NUM_REGS = 16;
    localparam int NCSR_OFF_W = 7;
    localparam int NCSR_IDX_LSB = 3;

    // Byte offsets of the registers.
    localparam logic [6:0] NCSR_OFF_SYSTEM_CONTROL = 7'h00;
    localparam logic [6:0] NCSR_OFF_TX_POLL_DEMAND = 7'h08;
    localparam logic [6:0] NCSR_OFF_RX_POLL_DEMAND = 7'h10;
    localparam logic [6:0] NCSR_OFF_RX_DESC_BASE = 7'h18;
    localparam logic [6:0] NCSR_OFF_TX_DESC_BASE = 7'h20;
    localparam logic [6:0] NCSR_OFF_NETWORK_STATUS = 7'h28;
    localparam logic [6:0] NCSR_OFF_OPERATION_MODE = 7'h30;
    localparam logic [6:0] NCSR_OFF_INTERRUPT_MASK = 7'h38;
    localparam logic [6:0] NCSR_OFF_STATISTICS = 7'h40;
    localparam logic [6:0] NCSR_OFF_MGMT_ACCESS = 7'h48;
    localparam logic [6:0] NCSR_OFF_ROM_ADDRESS = 7'h50;
    localparam logic [6:0] NCSR_OFF_GENERAL_TIMER = 7'h58;
    localparam logic [6:0] NCSR_OFF_PHY_STATUS = 7'h60;
    localparam logic [6:0] NCSR_OFF_FRAME_ACCESS = 7'h68;
    localparam logic [6:0] NCSR_OFF_FRAME_DATA = 7'h70;
    localparam logic [6:0] NCSR_OFF_WATCHDOG = 7'h78;

    // Reset value of each register, by index.
    localparam logic [31:0] NCSR_RST [NCSR_NUM_REGS] = '{
        32'hfec00000, 32'h0fffffff, 32'h0fffffff, 32'h00000000,
        32'h00000000, 32'hfc000000, 32'h02040000, 32'hfffe0000,
        32'h00000000, 32'h044097ff, 32'h00000000, 32'hfffe0000,
        32'hffffff00, 32'h00000000, 32'h00000000, 32'h00000000};

    // Bits that a host write stores; zero marks a read-only or write-only word.
    localparam logic [31:0] NCSR_WMASK [NCSR_NUM_REGS] = '{
        32'h002eff00, 32'h00000000, 32'h00000000, 32'hffffffff,
        32'hffffffff, 32'h00000000, 32'hffffffff, 32'hffffffff,
        32'h00000000, 32'hffffffff, 32'hffffffff, 32'hffffffff,
        32'h00000000, 32'hffffffff, 32'h00000000, 32'hffffffff};

    // System control fields.
    localparam int NCSR_RMS_BIT = 21;
    localparam int NCSR_POLL_LSB = 17;
    localparam int NCSR_ABA_LSB = 14;
    localparam int NCSR_BL_LSB = 8;
    localparam int NCSR_SRST_BIT = 0;

    localparam logic [3:0] NCSR_CMD_MEM_READ_MULT = 4'hc;
    localparam logic [3:0] NCSR_CMD_MEM_READ = 4'h6;

    // Length of the internal reset cycle in clocks.
    localparam logic [5:0] NCSR_SRST_CYCLES = 6'h20;

    // Auto-poll intervals in ns and in clocks at 10 MHz.
    localparam int NCSR_CLK_PERIOD_NS = 100;
    localparam int NCSR_POLL_200US_NS = 200000;
    localparam int NCSR_POLL_800US_NS = 800000;
    localparam int NCSR_POLL_1600US_NS = 1600000;
    localparam int NCSR_POLL_25US6_NS = 25600;
    localparam int NCSR_POLL_51US2_NS = 51200;
    localparam int NCSR_POLL_102US4_NS = 102400;
    localparam int NCSR_POLL_200US_CYC = NCSR_POLL_200US_NS / NCSR_CLK_PERIOD_NS;
    localparam int NCSR_POLL_800US_CYC = NCSR_POLL_800US_NS / NCSR_CLK_PERIOD_NS;
    localparam int NCSR_POLL_1600US_CYC = NCSR_POLL_1600US_NS / NCSR_CLK_PERIOD_NS;
    localparam int NCSR_POLL_25US6_CYC = NCSR_POLL_25US6_NS / NCSR_CLK_PERIOD_NS;
    localparam int NCSR_POLL_51US2_CYC = NCSR_POLL_51US2_NS / NCSR_CLK_PERIOD_NS;
    localparam int NCSR_POLL_102US4_CYC = NCSR_POLL_102US4_NS / NCSR_CLK_PERIOD_NS;

    typedef enum logic {NCSR_RUN, NCSR_SRST} ncsr_state_e;

    // One host access through either base address.
    typedef struct packed {
        logic io_sel;
        logic mem_sel;
        logic write;
        logic [6:0] offset;
        logic [31:0] wdata;
    } ncsr_req_s;

    // Update of a read-only word by the controller's own logic.
    typedef struct packed {
        logic load;
        logic [3:0] index;
        logic [31:0] data;
    } ncsr_ro_s;

endpackage : ncsr_pkg

// ### rtl/ncsr_bank.sv
/*
 * Host register bank with the system control register of the Ethernet controller.
 * Assumes host accesses arrive already decoded to a byte offset from either base,
 * and that the DMA and descriptor engines consume the control outputs.
 */
`timescale 1ns/1ns
`default_nettype none
module ncsr_bank
    import ncsr_pkg::*;
#(
    parameter int POLL_800US_CYC = NCSR_POLL_800US_CYC,
    parameter int POLL_1600US_CYC = NCSR_POLL_1600US_CYC,
    parameter int FIFO_CNT_W = 8
) (
    // Clock, reset and enable.
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // Host access.
    input wire ncsr_req_s i_req,
    output logic o_ack,
    output logic [31:0] o_rdata,
    // Read-only word updates.
    input wire ncsr_ro_s i_ro,
    // Controller state.
    input wire logic i_tx_suspended,
    input wire logic [4:0] i_dma_addr,
    input wire logic [FIFO_CNT_W-1:0] i_fifo_avail,
    // Control towards the engines.
    output logic o_soft_reset,
    output logic o_tx_poll,
    output logic o_rx_poll,
    output logic [3:0] o_read_cmd,
    output logic [FIFO_CNT_W-1:0] o_burst_dwords
);

    ////////////////////////////////////////////////////////////////////////////
    // Storage and decode.

    logic [31:0] csr_reg [NCSR_NUM_REGS];
    ncsr_state_e state_reg;
    logic [5:0] srst_cnt_reg;
    logic [15:0] poll_cnt_reg;

    wire logic busy = (state_reg == NCSR_SRST);
    wire logic req_take = (i_req.io_sel || i_req.mem_sel) && !busy;
    wire logic req_mapped = (i_req.offset[NCSR_IDX_LSB-1:0] == 3'h0);
    wire logic [3:0] req_idx = i_req.offset[NCSR_OFF_W-1:NCSR_IDX_LSB];
    wire logic wr_hit = req_take && i_req.write && req_mapped;
    wire logic wr_sysctl = wr_hit && (i_req.offset == NCSR_OFF_SYSTEM_CONTROL);
    wire logic srst_start = wr_sysctl && i_req.wdata[NCSR_SRST_BIT];
    wire logic tx_demand = wr_hit && (i_req.offset == NCSR_OFF_TX_POLL_DEMAND);
    wire logic rx_demand = wr_hit && (i_req.offset == NCSR_OFF_RX_POLL_DEMAND);
    wire logic ro_ok = i_ro.load && (NCSR_WMASK[i_ro.index] == 32'h00000000);
    wire logic [31:0] rd_word = (req_mapped && !i_req.write) ? csr_reg[req_idx] : 32'h00000000;

    wire logic [31:0] sysctl = csr_reg[0];
    wire logic [2:0] poll_code = sysctl[NCSR_POLL_LSB +: 3];
    wire logic [1:0] aba_code = sysctl[NCSR_ABA_LSB +: 2];
    wire logic [5:0] bl_field = sysctl[NCSR_BL_LSB +: 6];

    ////////////////////////////////////////////////////////////////////////////
    // Functions.

    // Interval of one auto-poll code in clocks; zero means no polling.
    function automatic logic [15:0] poll_cycles(input logic [2:0] code);
        case (code)
            3'h1: poll_cycles = 16'(NCSR_POLL_200US_CYC);
            3'h2: poll_cycles = 16'(POLL_800US_CYC);
            3'h3: poll_cycles = 16'(POLL_1600US_CYC);
            3'h5: poll_cycles = 16'(NCSR_POLL_25US6_CYC);
            3'h6: poll_cycles = 16'(NCSR_POLL_51US2_CYC);
            3'h7: poll_cycles = 16'(NCSR_POLL_102US4_CYC);
            default: poll_cycles = 16'h0000;
        endcase
    endfunction : poll_cycles

    // Doublewords left before the programmed boundary; zero when code 00.
    function automatic logic [5:0] room_to_bound(input logic [1:0] aba, input logic [4:0] addr);
        logic [5:0] bnd;
        bnd = 6'h00;
        case (aba)
            2'h1: bnd = 6'h08;
            2'h2: bnd = 6'h10;
            2'h3: bnd = 6'h20;
            default: bnd = 6'h00;
        endcase
        room_to_bound = (bnd == 6'h00) ? 6'h00 : bnd - (6'(addr) & (bnd - 6'h01));
    endfunction : room_to_bound

    wire logic [15:0] poll_len = poll_cycles(poll_code);
    wire logic poll_on = i_tx_suspended && (poll_len != 16'h0000);
    wire logic poll_fire = poll_on && (poll_cnt_reg >= poll_len - 16'h0001);
    wire logic [5:0] room = room_to_bound(aba_code, i_dma_addr);
    wire logic [FIFO_CNT_W-1:0] len_bl = (bl_field != 6'h00 && FIFO_CNT_W'(bl_field) < i_fifo_avail)
        ? FIFO_CNT_W'(bl_field) : i_fifo_avail;
    wire logic [FIFO_CNT_W-1:0] burst_next = (room != 6'h00 && FIFO_CNT_W'(room) < len_bl)
        ? FIFO_CNT_W'(room) : len_bl;

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < NCSR_NUM_REGS; i++) begin
                csr_reg[i] <= NCSR_RST[i];
            end
        end else if (i_clk_en) begin
            if (busy) begin
                for (int i = 0; i < NCSR_NUM_REGS; i++) begin
                    csr_reg[i] <= NCSR_RST[i];
                end
            end else begin
                if (wr_hit) begin
                    csr_reg[req_idx] <= (csr_reg[req_idx] & ~NCSR_WMASK[req_idx])
                        | (i_req.wdata & NCSR_WMASK[req_idx]);
                end
                if (ro_ok) begin
                    csr_reg[i_ro.index] <= i_ro.data;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Host answer, software reset and polling.

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_ack <= 1'b0;
            o_rdata <= 32'h00000000;
        end else if (i_clk_en) begin
            o_ack <= req_take;
            o_rdata <= rd_word;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= NCSR_RUN;
            srst_cnt_reg <= 6'h00;
        end else if (i_clk_en) begin
            case (state_reg)
                NCSR_RUN: begin
                    if (srst_start) begin
                        state_reg <= NCSR_SRST;
                        srst_cnt_reg <= NCSR_SRST_CYCLES - 6'h01;
                    end
                end
                NCSR_SRST: begin
                    if (srst_cnt_reg == 6'h00) begin
                        state_reg <= NCSR_RUN;
                    end else begin
                        srst_cnt_reg <= srst_cnt_reg - 6'h01;
                    end
                end
                default: state_reg <= NCSR_RUN;
            endcase
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            poll_cnt_reg <= 16'h0000;
            o_tx_poll <= 1'b0;
            o_rx_poll <= 1'b0;
        end else if (i_clk_en) begin
            poll_cnt_reg <= (poll_on && !poll_fire) ? poll_cnt_reg + 16'h0001 : 16'h0000;
            o_tx_poll <= tx_demand || poll_fire;
            o_rx_poll <= rx_demand;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_read_cmd <= NCSR_CMD_MEM_READ;
            o_burst_dwords <= '0;
        end else if (i_clk_en) begin
            o_read_cmd <= sysctl[NCSR_RMS_BIT] ? NCSR_CMD_MEM_READ_MULT : NCSR_CMD_MEM_READ;
            o_burst_dwords <= burst_next;
        end
    end

    assign o_soft_reset = busy;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    sequence s_srst_begin;
        srst_start;
    endsequence

    sequence s_srst_running;
        busy && (srst_cnt_reg == NCSR_SRST_CYCLES - 6'h01);
    endsequence

    a_unmapped_reads_zero: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (req_take && !req_mapped) |=> (o_ack && o_rdata == 32'h00000000))
        else $error("unmapped offset did not read as zero");

    a_either_space_acks: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (i_req.io_sel || i_req.mem_sel) && !busy |=> o_ack)
        else $error("access through a base address was not answered");

    a_srst_reloads_mode: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        busy |=> (csr_reg[6] == 32'h02040000))
        else $error("operation mode not at default after software reset");

    a_srst_reloads_ctrl: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        $fell(busy) |-> (csr_reg[0] == 32'hfec00000) && (csr_reg[9] == 32'h044097ff))
        else $error("defaults not restored after software reset");

    a_read_cmd_select: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        ##1 o_read_cmd == ($past(sysctl[NCSR_RMS_BIT]) ? NCSR_CMD_MEM_READ_MULT : NCSR_CMD_MEM_READ))
        else $error("wrong burst read command");

    a_poll_cause: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        o_tx_poll |-> $past(tx_demand) || ($past(i_tx_suspended) && $past(poll_code) != 3'h0))
        else $error("transmit poll without a cause");

    a_poll_interval: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (poll_code == 3'h7 && poll_on) |-> poll_cnt_reg < 16'(NCSR_POLL_102US4_CYC))
        else $error("poll counter ran past its interval");

    a_burst_boundary: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (aba_code == 2'h1) |=> (o_burst_dwords + FIFO_CNT_W'($past(i_dma_addr[2:0])) <= FIFO_CNT_W'(8)))
        else $error("burst crosses the 8 doubleword boundary");

    a_burst_fifo: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        1'b1 |=> o_burst_dwords <= $past(i_fifo_avail))
        else $error("burst longer than the FIFO allows");

    a_burst_length: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (bl_field != 6'h00) |=> o_burst_dwords <= FIFO_CNT_W'($past(bl_field)))
        else $error("burst longer than the programmed length");

    a_srst_start: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        s_srst_begin |=> s_srst_running ##1 busy[*8])
        else $error("software reset cycle did not start");

    a_srst_ends: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        $fell(busy) |-> $past(srst_cnt_reg) == 6'h00)
        else $error("software reset cycle ended early");

    a_demand_poll: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (tx_demand |=> o_tx_poll) and (rx_demand |=> o_rx_poll))
        else $error("poll demand write did not start a fetch");

    a_ack_needs_request: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (o_ack && $past(i_clk_en)) |-> $past(req_take))
        else $error("acknowledge without a taken request");

    a_busy_refuses: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        busy |=> !o_ack)
        else $error("access answered during the reset cycle");

    a_desc_base_write: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (wr_hit && i_req.offset == NCSR_OFF_RX_DESC_BASE) |=> csr_reg[3] == $past(i_req.wdata))
        else $error("descriptor base write did not land");

    a_sysctl_read: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (req_take && !i_req.write && i_req.offset == NCSR_OFF_SYSTEM_CONTROL) |=> o_rdata == $past(sysctl))
        else $error("system control read returned a wrong word");

    a_write_reads_zero: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (req_take && i_req.write) |=> o_rdata == 32'h00000000)
        else $error("write answered with nonzero data");

    a_rx_poll_cause: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (o_rx_poll && $past(i_clk_en)) |-> $past(rx_demand))
        else $error("receive poll without a demand write");

    a_poll_idle_quiet: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (!i_tx_suspended && !tx_demand) |=> !o_tx_poll)
        else $error("transmit poll while not suspended");

    a_poll_cnt_clears: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        !i_tx_suspended |=> poll_cnt_reg == 16'h0000)
        else $error("poll counter kept running after suspension ended");

    a_poll_51us_fire: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (poll_code == 3'h6 && poll_on && poll_cnt_reg == 16'(NCSR_POLL_51US2_CYC - 1)) |=> o_tx_poll)
        else $error("poll did not fire at the end of its interval");

    a_burst_not_empty: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (i_fifo_avail != '0) |=> o_burst_dwords != '0)
        else $error("empty burst although the FIFO allows one");

    a_burst_fifo_only: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (bl_field == 6'h00 && aba_code == 2'h0) |=> o_burst_dwords == $past(i_fifo_avail))
        else $error("unlimited burst not set by the FIFO level");

    a_ro_load_lands: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        (ro_ok && !busy) |=> csr_reg[$past(i_ro.index)] == $past(i_ro.data))
        else $error("read-only word update did not land");

    a_srst_clears_base: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        busy |=> csr_reg[3] == NCSR_RST[3])
        else $error("descriptor base not at default during software reset");

    a_mrm_stored: assert property (@(posedge i_clock) disable iff (i_rst || !i_clk_en)
        wr_sysctl |=> sysctl[NCSR_RMS_BIT] == $past(i_req.wdata[NCSR_RMS_BIT]))
        else $error("read multiple select not stored");

endmodule : ncsr_bank
`default_nettype wire

// ### testbench/ncsr_host_model.sv
/*
 * Behavioural host that makes single-word accesses to the register bank.
 * Assumes the bank takes a request on one edge and answers with a one-cycle acknowledge.
 */
`timescale 1ns/1ns
`default_nettype none
module ncsr_host_model
    import ncsr_pkg::*;
(
    // Clock.
    input wire logic i_clock,
    // Answer from the bank.
    input wire logic i_ack,
    input wire logic [31:0] i_rdata,
    // Request towards the bank.
    output ncsr_req_s o_req
);
    initial begin
        o_req = '0;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic access(input logic io, input logic wr, input logic [6:0] off, input logic [31:0] wd,
                          output logic acked, output logic [31:0] rd);
        int n;
        acked = 1'b0;
        rd = '0;
        @(posedge i_clock);
        #1;
        o_req = '{io_sel: io, mem_sel: !io, write: wr, offset: off, wdata: wd};
        @(posedge i_clock);
        #1;
        // A released bus drops both selects and shows the inverse of its last write, offset and data, not a stale copy.
        o_req = '{io_sel: 1'b0, mem_sel: 1'b0, write: !wr, offset: ~off, wdata: ~wd};
        for (n = 0; n < 3 && !acked; n++) begin
            if (i_ack === 1'b1) begin
                acked = 1'b1;
                rd = i_rdata;
            end else begin
                @(posedge i_clock);
                #1;
            end
        end
        if (wr && off == NCSR_OFF_SYSTEM_CONTROL && wd[NCSR_SRST_BIT]) begin
            repeat (34) @(posedge i_clock);
            #1;
        end
    endtask : access
endmodule : ncsr_host_model
`default_nettype wire

// ### testbench/test_ncsr_bank.sv
/*
 * Self-checking bench of the register bank: defaults, access paths, system control fields,
 * poll commands, auto-poll intervals and software reset.
 * Assumes the 800 us and 1600 us poll intervals are shortened through the bank's parameters.
 */
`timescale 1ns/1ns
`default_nettype none
module test_ncsr_bank;
    import ncsr_pkg::*;
    localparam int P800 = 80;
    localparam int P1600 = 160;
    logic i_clock = 1'b0;
    logic i_rst = 1'b1;
    logic clk_en = 1'b1;
    logic tx_susp = 1'b0;
    logic [4:0] dma_addr = '0;
    logic [7:0] fifo_avail = '0;
    ncsr_ro_s ro = '0;
    ncsr_req_s req;
    logic ack, tx_poll, rx_poll, soft_rst;
    logic [31:0] rdata;
    logic [3:0] read_cmd;
    logic [7:0] burst;
    logic acked;
    logic [31:0] rd;
    int err_total = 0;
    int n_tests = 0;
    int tx_cnt = 0;
    int rx_cnt = 0;
    int srst_cnt = 0;
    logic [31:0] exp_rst [16] = '{32'hfec00000, 32'h0fffffff, 32'h0fffffff, 32'h0, 32'h0, 32'hfc000000,
        32'h02040000, 32'hfffe0000, 32'h0, 32'h044097ff, 32'h0, 32'hfffe0000, 32'hffffff00, 32'h0, 32'h0, 32'h0};
    int per [8] = '{0, 2000, P800, P1600, 0, 256, 512, 1024};
    logic [5:0] bl_t [5] = '{6'h00, 6'h04, 6'h04, 6'h20, 6'h08};
    logic [1:0] aba_t [5] = '{2'h0, 2'h1, 2'h0, 2'h3, 2'h2};
    logic [4:0] ad_t [5] = '{5'h05, 5'h06, 5'h06, 5'h00, 5'h09};
    logic [7:0] ff_t [5] = '{8'h14, 8'h14, 8'h03, 8'h28, 8'h28};
    logic [7:0] ex_t [5] = '{8'h14, 8'h02, 8'h03, 8'h20, 8'h07};

    always #50 i_clock = ~i_clock;

    ncsr_bank #(.POLL_800US_CYC(P800), .POLL_1600US_CYC(P1600), .FIFO_CNT_W(8)) dut_u (
        .i_clock(i_clock), .i_rst(i_rst), .i_clk_en(clk_en), .i_req(req), .o_ack(ack), .o_rdata(rdata),
        .i_ro(ro), .i_tx_suspended(tx_susp), .i_dma_addr(dma_addr), .i_fifo_avail(fifo_avail),
        .o_soft_reset(soft_rst), .o_tx_poll(tx_poll), .o_rx_poll(rx_poll), .o_read_cmd(read_cmd),
        .o_burst_dwords(burst));

    ncsr_host_model host_u (.i_clock(i_clock), .i_ack(ack), .i_rdata(rdata), .o_req(req));

    always @(posedge i_clock) begin
        tx_cnt += (tx_poll === 1'b1);
        rx_cnt += (rx_poll === 1'b1);
        srst_cnt += (soft_rst === 1'b1);
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : stop_test

    task automatic rd_chk(input logic io, input logic [6:0] off, input logic [31:0] exp);
        host_u.access(io, 1'b0, off, 32'h0, acked, rd);
        chk("read ack", 32'h1, {31'h0, acked});
        chk("read data", exp, rd);
    endtask : rd_chk

    task automatic wr(input logic io, input logic [6:0] off, input logic [31:0] wd);
        host_u.access(io, 1'b1, off, wd, acked, rd);
        chk("write ack", 32'h1, {31'h0, acked});
    endtask : wr

    ////////////////////////////////////////////////////////////////////////
    initial begin
        #(100 * 20000);
        err_total++;
        stop_test();
    end

    initial begin
        repeat (4) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        for (int i = 0; i < 16; i++) begin
            rd_chk(i[0], 7'(i * 8), exp_rst[i]);
        end
        chk("read command", 32'h6, {28'h0, read_cmd});
        wr(1'b1, NCSR_OFF_RX_DESC_BASE, 32'h1234_5678);
        rd_chk(1'b0, NCSR_OFF_RX_DESC_BASE, 32'h1234_5678);
        rd_chk(1'b1, 7'h1c, 32'h0);
        wr(1'b0, NCSR_OFF_SYSTEM_CONTROL, 32'h002e_c400);
        rd_chk(1'b1, NCSR_OFF_SYSTEM_CONTROL, 32'hfeee_c400);
        chk("control fields", 32'h002e_c400, rd & 32'h002e_ff00);
        chk("read command", 32'hc, {28'h0, read_cmd});
        for (int i = 0; i < 5; i++) begin
            wr(1'b1, NCSR_OFF_SYSTEM_CONTROL, {16'h0, aba_t[i], bl_t[i], 8'h0});
            dma_addr = ad_t[i];
            fifo_avail = ff_t[i];
            repeat (2) @(posedge i_clock);
            #1;
            chk("burst length", {24'h0, ex_t[i]}, {24'h0, burst});
            chk("read command", 32'h6, {28'h0, read_cmd});
        end
        tx_cnt = 0;
        wr(1'b0, NCSR_OFF_TX_POLL_DEMAND, 32'h0);
        wr(1'b1, NCSR_OFF_RX_POLL_DEMAND, 32'h0);
        wr(1'b0, NCSR_OFF_RX_POLL_DEMAND, 32'h0);
        @(posedge i_clock);
        #1;
        chk("tx poll count", 32'h1, 32'(tx_cnt));
        chk("rx poll count", 32'h2, 32'(rx_cnt));
        for (int c = 0; c < 8; c++) begin
            wr(1'b1, NCSR_OFF_SYSTEM_CONTROL, {12'h0, 3'(c), 17'h0});
            tx_cnt = 0;
            tx_susp = 1'b1;
            repeat (1100) @(posedge i_clock);
            #1;
            tx_susp = 1'b0;
            chk("auto poll count", (per[c] > 0) ? 32'(1100 / per[c]) : 32'h0, 32'(tx_cnt));
        end
        @(posedge i_clock);
        #1;
        ro = '{load: 1'b1, index: 4'h8, data: 32'h0000_00a5};
        @(posedge i_clock);
        #1;
        ro = '0;
        rd_chk(1'b0, NCSR_OFF_STATISTICS, 32'h0000_00a5);
        wr(1'b1, NCSR_OFF_SYSTEM_CONTROL, 32'h0020_0000);
        srst_cnt = 0;
        wr(1'b0, NCSR_OFF_SYSTEM_CONTROL, 32'h0020_0001);
        chk("reset cycle length", 32'h20, 32'(srst_cnt));
        chk("read command", 32'h6, {28'h0, read_cmd});
        rd_chk(1'b1, NCSR_OFF_SYSTEM_CONTROL, 32'hfec0_0000);
        rd_chk(1'b0, NCSR_OFF_RX_DESC_BASE, 32'h0);
        rd_chk(1'b1, NCSR_OFF_STATISTICS, 32'h0);
        @(posedge i_clock);
        #1;
        clk_en = 1'b0;
        host_u.access(1'b0, 1'b1, NCSR_OFF_RX_DESC_BASE, 32'h5a5a_5a5a, acked, rd);
        chk("frozen ack", 32'h0, {31'h0, acked});
        clk_en = 1'b1;
        rd_chk(1'b0, NCSR_OFF_RX_DESC_BASE, 32'h0);
        stop_test();
    end
endmodule : test_ncsr_bank
`default_nettype wire
